// >>> include/smr_pkg.sv
// constants and carrier types for the serial multiply/divide result stage
// assumes one 125 MHz clock; minor cycles come from an internal divider
package smr_pkg;
    localparam int MAG_W          = 43;
    localparam int ADDR_W         = 10;
    localparam int PROD_W         = 86;
    localparam int MUL_STEPS      = 43;
    localparam int DIV_STEPS      = 44;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int MINOR_CYCLE_NS = 32;
    localparam int MINOR_CLKS     = (MINOR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_W         = 6;
    localparam logic [1:0] TICK_LAST = 2'(MINOR_CLKS - 1);
    localparam logic [STEP_W-1:0] MUL_STEPS_V = 6'(MUL_STEPS);
    localparam logic [STEP_W-1:0] DIV_STEPS_V = 6'(DIV_STEPS);
    localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
    localparam logic [MAG_W-1:0] MAG_ZERO = 43'h0;
    localparam logic [MAG_W-1:0] MAG_ONES = 43'h7ffffffffff;
    localparam logic [PROD_W-1:0] ROUND_HALF = 86'h1 << 42;

    // digits c1..c43 in mag (c1 is the msb), sign set means minus
    typedef struct packed {
        logic [MAG_W-1:0] mag;
        logic             sign;
    } smr_word_type;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        smr_word_type      data;
    } smr_store_type;

    typedef enum logic [1:0] {
        ORD_MUL_ROUND = 2'b00,
        ORD_MUL_EXACT = 2'b01,
        ORD_DIV_ROUND = 2'b10
    } smr_order_type;

    typedef enum logic [2:0] {
        ST_OPER_A = 3'b000,
        ST_OPER_B = 3'b001,
        ST_RUN    = 3'b010,
        ST_STORE  = 3'b011,
        ST_LOW    = 3'b100,
        ST_NEXT   = 3'b101
    } smr_state_type;

    localparam smr_word_type WORD_ZERO = '{mag: 43'h0, sign: 1'b0};
endpackage

// >>> logic/smr_serial_div.sv
// non-restoring serial divider, one quotient digit per step
// assumes step pulses come one per minor cycle from the parent
`timescale 1ns/1ns
module smr_serial_div
    import smr_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control
    input  wire logic             start,
    input  wire logic             step,
    // operands, magnitudes only
    input  wire logic [MAG_W-1:0] dividend,
    input  wire logic [MAG_W-1:0] divisor,
    // result
    output logic                  done,
    output logic                  overflow,
    output logic [MAG_W-1:0]      quot
);
    logic signed [45:0] rem;
    logic [43:0]        q;
    logic [STEP_W-1:0]  cnt;
    logic signed [45:0] next_rem;
    logic [43:0]        rounded;
    logic [MAG_W-1:0]   held_divisor;

    // remainder sign picks subtract or add; no restore step needed
    always_comb begin
        if (rem[45] == 1'b0) begin
            next_rem = (rem <<< 1) - $signed({3'b000, held_divisor});
        end else begin
            next_rem = (rem <<< 1) + $signed({3'b000, held_divisor});
        end
    end

    // extra digit gives the half unit; carries run the full width
    // no carry out: the largest legal quotient rounds to all ones
    assign rounded = q + 44'h1; // (RULE_15)

    always_ff @(posedge clk) begin
        if (rst) begin
            rem          <= '0;
            q            <= '0;
            cnt          <= '0;
            done         <= 1'b0;
            overflow     <= 1'b0;
            held_divisor <= MAG_ZERO;
        end else if (start) begin
            // divisor port is only valid during the execute
            held_divisor <= divisor;
            rem      <= $signed({3'b000, dividend});
            q        <= '0;
            cnt      <= '0;
            done     <= 1'b0;
            overflow <= (divisor == MAG_ZERO) || (dividend >= divisor); // (RULE_11)
        end else if (step && !done) begin
            rem <= next_rem;
            q   <= {q[42:0], ~next_rem[45]}; // (RULE_17)
            cnt <= cnt + 6'h01;
            if (cnt == DIV_STEPS_V - 6'h01) begin
                done <= 1'b1;
            end
        end
    end

    // the saturated digit field replaces the quotient on overflow
    assign quot = overflow ? MAG_ONES : rounded[43:1]; // (RULE_13)

    a_div_digits : assert property (@(posedge clk) disable iff (rst)
        $rose(done) |-> cnt == DIV_STEPS_V) // (RULE_17)
        else $error("divider finished after a wrong digit count");
    a_div_round : assert property (@(posedge clk) disable iff (rst)
        done && !overflow && q[0] |-> quot == q[43:1] + 43'h1) // (RULE_15)
        else $error("rounded quotient lost the half unit");
endmodule

// >>> logic/smr_result_store.sv
// result stage: exact multiply pair store and rounded divide
// assumes dispatcher and memory share CLOCK; executes are one-cycle pulses
//
// Overview of operation
// (RULE_01) exact multiply stores the unrounded product as two words
// (RULE_02) high word is the 43 upper product digits, truncated
// (RULE_03) low word is the 43 lower digits shifted up by 43
// (RULE_04) a zero high word always carries a plus sign
// (RULE_05) a zero low word always carries a plus sign
// (RULE_06) exact multiply's first three executes match rounded multiply
// (RULE_07) next address is third address plus one
// (RULE_08) low word is stored exactly one minor cycle after the high word
// (RULE_09) position 1023 is followed cyclically by position 0
// (RULE_10) fifth execute passes the fourth-address word on as next order; the code passes it on at the fourth execute
// (RULE_11) divide raises capacity exceeded for quotient >= 1 or zero divisor
// (RULE_12) capacity exceeded never halts; a defined word is still stored
// (RULE_13) overflow word has all digits set to one
// (RULE_14) overflow sign follows the rule of signs
// (RULE_15) rounded quotient adds half a unit before dropping digits
// (RULE_16) multiply store comes no sooner than 43 minor cycles after execute two
// (RULE_17) division is non-restoring, one digit per minor cycle, 44 digits
// (RULE_18) result words hold 43 digits and a sign; zero is plus
`timescale 1ns/1ns
module smr_result_store
    import smr_pkg::*;
(
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              SYS_RST,
    // dispatcher side
    input  wire logic              EXEC,
    input  wire logic [1:0]        ORDER_KIND,
    input  wire logic [ADDR_W-1:0] EXEC_ADDR,
    output logic                   RESULT_READY,
    output logic                   CAP_EXCEEDED,
    output logic                   ORDER_VALID,
    output smr_word_type           ORDER_WORD,
    output logic [ADDR_W-1:0]      GEN_ADDR,
    // memory side
    input  wire smr_word_type      MEM_RDATA,
    output smr_store_type          MEM_STORE
);
    smr_state_type      state;
    smr_order_type      kind;
    smr_word_type       op_a;
    smr_word_type       op_b;
    logic [1:0]         tick_cnt;
    logic               tick;
    logic [STEP_W-1:0]  step_cnt;
    logic [PROD_W-1:0]  prod;
    logic [MAG_W-1:0]   mplier;
    logic               div_start;
    logic               div_done;
    logic               div_ovf;
    logic [MAG_W-1:0]   div_quot;
    logic               sign_res;
    logic [PROD_W-1:0]  rounded;
    logic               run_done;
    logic               is_div;
    logic               is_exact;
    logic               wr_high;
    logic               wr_low;
    logic               phase_sync;

    // shift-add step; adding before the shift keeps every carry
    function automatic logic [PROD_W-1:0] mul_step(
        input logic [PROD_W-1:0] acc,
        input logic [MAG_W-1:0]  m,
        input logic              b
    );
        logic [PROD_W:0] s;
        s = {1'b0, acc} + (b ? {1'b0, m, MAG_ZERO} : '0);
        return s[PROD_W:1];
    endfunction

    // a zero digit field is always plus, whatever the true sign
    function automatic smr_word_type make_word(
        input logic [MAG_W-1:0] mag,
        input logic             neg
    );
        smr_word_type w;
        w.mag  = mag;
        w.sign = neg && (mag != MAG_ZERO); // (RULE_04) (RULE_05) (RULE_18)
        return w;
    endfunction

    assign is_div    = (kind == ORD_DIV_ROUND);
    assign is_exact  = (kind == ORD_MUL_EXACT);
    assign sign_res  = op_a.sign ^ op_b.sign; // (RULE_14)
    assign rounded   = prod + ROUND_HALF;
    assign div_start = (state == ST_OPER_B) && EXEC && is_div;
    assign run_done  = is_div ? div_done : (step_cnt == MUL_STEPS_V);
    assign wr_high   = (state == ST_STORE) && EXEC;
    assign wr_low    = (state == ST_LOW) && tick;
    assign phase_sync = ((state == ST_OPER_B) && EXEC) || wr_high;

    // minor cycle divider
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            tick_cnt <= 2'h0;
            tick     <= 1'b0;
        end else if (phase_sync) begin
            // restart so the first tick is a full minor cycle away
            tick_cnt <= 2'h1; // (RULE_08) (RULE_16)
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_LAST) begin
            tick_cnt <= 2'h0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 2'h1;
            tick     <= 1'b0;
        end
    end

    // execute sequencing
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state        <= ST_OPER_A;
            RESULT_READY <= 1'b0;
        end else begin
            unique case (state)
                ST_OPER_A: begin
                    if (EXEC) begin
                        state <= ST_OPER_B;
                    end
                end
                ST_OPER_B: begin
                    if (EXEC) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // store not offered until the serial work is over
                    if (run_done) begin // (RULE_06) (RULE_16)
                        state        <= ST_STORE;
                        RESULT_READY <= 1'b1;
                    end
                end
                ST_STORE: begin
                    if (EXEC) begin
                        state        <= is_exact ? ST_LOW : ST_NEXT; // (RULE_01)
                        RESULT_READY <= 1'b0;
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        state <= ST_NEXT; // (RULE_08)
                    end
                end
                ST_NEXT: begin
                    if (EXEC) begin
                        state <= ST_OPER_A; // (RULE_10)
                    end
                end
                default: begin
                    state        <= ST_OPER_A;
                    RESULT_READY <= 1'b0;
                end
            endcase
        end
    end

    // operand capture
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            kind <= ORD_MUL_ROUND;
            op_a <= WORD_ZERO;
            op_b <= WORD_ZERO;
        end else if (EXEC && state == ST_OPER_A) begin
            // unknown kind code falls back to rounded multiply
            kind <= (ORDER_KIND == 2'b11) ? ORD_MUL_ROUND : smr_order_type'(ORDER_KIND);
            op_a <= MEM_RDATA;
        end else if (EXEC && state == ST_OPER_B) begin
            op_b <= MEM_RDATA;
        end
    end

    // serial multiplier, one multiplier digit per minor cycle
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            prod     <= '0;
            mplier   <= MAG_ZERO;
            step_cnt <= '0;
        end else if (EXEC && state == ST_OPER_B) begin
            prod     <= '0;
            mplier   <= MEM_RDATA.mag;
            step_cnt <= '0;
        end else if (state == ST_RUN && tick && step_cnt < DIV_STEPS_V) begin
            step_cnt <= step_cnt + 6'h01; // (RULE_16)
            if (!is_div && step_cnt < MUL_STEPS_V) begin
                prod   <= mul_step(prod, op_a.mag, mplier[0]);
                mplier <= {1'b0, mplier[MAG_W-1:1]};
            end
        end
    end

    smr_serial_div u_div (
        .clk      (CLOCK),
        .rst      (SYS_RST),
        .start    (div_start),
        .step     (tick && state == ST_RUN && is_div),
        .dividend (op_a.mag),
        .divisor  (MEM_RDATA.mag),
        .done     (div_done),
        .overflow (div_ovf),
        .quot     (div_quot)
    );

    // capacity signal stays up until the next order begins
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            CAP_EXCEEDED <= 1'b0;
        end else if (state == ST_RUN && is_div && div_done && div_ovf) begin
            CAP_EXCEEDED <= 1'b1; // (RULE_11)
        end else if (EXEC && state == ST_OPER_A) begin
            CAP_EXCEEDED <= 1'b0;
        end
    end

    // memory stores; divide keeps going after overflow
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            MEM_STORE <= '{write: 1'b0, addr: ADDR_RST, data: WORD_ZERO};
            GEN_ADDR  <= ADDR_RST;
        end else if (wr_high) begin
            MEM_STORE.write <= 1'b1;
            MEM_STORE.addr  <= EXEC_ADDR;
            // 10-bit sum wraps 1023 to 0 by itself
            GEN_ADDR <= EXEC_ADDR + ADDR_ONE; // (RULE_07) (RULE_09)
            unique case (kind)
                ORD_MUL_EXACT: MEM_STORE.data <= make_word(prod[85:43], sign_res); // (RULE_02)
                ORD_MUL_ROUND: MEM_STORE.data <= make_word(rounded[85:43], sign_res);
                ORD_DIV_ROUND: MEM_STORE.data <= make_word(div_quot, sign_res); // (RULE_12)
            endcase
        end else if (wr_low) begin
            MEM_STORE.write <= 1'b1; // (RULE_08)
            MEM_STORE.addr  <= GEN_ADDR;
            MEM_STORE.data  <= make_word(prod[42:0], sign_res); // (RULE_03)
        end else begin
            MEM_STORE.write <= 1'b0;
        end
    end

    // next order hand-off
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ORDER_VALID <= 1'b0;
            ORDER_WORD  <= WORD_ZERO;
        end else begin
            ORDER_VALID <= EXEC && state == ST_NEXT; // (RULE_10)
            if (EXEC && state == ST_NEXT) begin
                ORDER_WORD <= MEM_RDATA;
            end
        end
    end

    // helper: was the last store the low half of a pair
    logic low_done;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            low_done <= 1'b0;
        end else begin
            low_done <= wr_low;
        end
    end

    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_plus_zero : assert property (
        MEM_STORE.write && MEM_STORE.data.mag == MAG_ZERO |-> !MEM_STORE.data.sign) // (RULE_04)
        else $error("zero result word stored with minus sign");
    a_low_wraps : assert property (
        low_done |-> MEM_STORE.addr == $past(MEM_STORE.addr, 1) + ADDR_ONE) // (RULE_09)
        else $error("low word not at next cyclic address");
    a_pair_lag : assert property (
        wr_high && is_exact |=> MEM_STORE.write && !low_done ##4 (MEM_STORE.write && low_done)) // (RULE_08)
        else $error("low word not stored one minor cycle after high word");
    a_exact_high : assert property (
        wr_high && is_exact |=> MEM_STORE.data.mag == prod[85:43]) // (RULE_02)
        else $error("exact high word differs from upper product digits");
    a_exact_low : assert property (
        low_done |-> MEM_STORE.data.mag == prod[42:0]) // (RULE_03)
        else $error("exact low word differs from lower product digits");
    a_store_early : assert property (
        $rose(RESULT_READY) && !is_div |-> step_cnt >= MUL_STEPS_V) // (RULE_16)
        else $error("multiply result offered too early");
    a_cap_word : assert property (
        wr_high && is_div && CAP_EXCEEDED |=> MEM_STORE.write
            && MEM_STORE.data.mag == MAG_ONES && MEM_STORE.data.sign == sign_res) // (RULE_13)
        else $error("overflow word wrong");
    a_cap_raise : assert property (
        state == ST_RUN && is_div && div_done && div_ovf |=> CAP_EXCEEDED [*1] ##1
            (CAP_EXCEEDED || state != ST_RUN)) // (RULE_11)
        else $error("capacity exceeded not raised");
    a_order_pass : assert property (
        EXEC && state == ST_NEXT |=> ORDER_VALID && ORDER_WORD == $past(MEM_RDATA)) // (RULE_10)
        else $error("next order not passed on");

    c_exact_pair : cover property (wr_high && is_exact ##[1:4] wr_low);
    c_div_over : cover property (wr_high && is_div && CAP_EXCEEDED);
    c_div_plain : cover property (wr_high && is_div && !CAP_EXCEEDED);
    c_mul_round : cover property (wr_high && kind == ORD_MUL_ROUND);
    c_wrap : cover property (wr_high && is_exact && EXEC_ADDR == 10'h3ff);
endmodule

// >>> sim/smr_partner.sv
// dispatcher and recirculating word memory model facing the result stage
// assumes one shared clock; executes are single-cycle pulses issued by task calls
`timescale 1ns/1ns
module smr_partner
    import smr_pkg::*;
(
    // clock
    input  wire logic              CLOCK,
    // dispatcher side
    output logic                   EXEC,
    output logic [1:0]             ORDER_KIND,
    output logic [ADDR_W-1:0]      EXEC_ADDR,
    // memory side
    input  wire smr_store_type     MEM_STORE,
    output smr_word_type           MEM_RDATA
);
    smr_word_type   mem [1024];
    logic [MAG_W:0] noise = 44'h5a5;

    initial begin
        EXEC = 1'b0;
        ORDER_KIND = 2'b00;
        EXEC_ADDR = 10'h000;
    end

    // a store lands in the addressed position, displacing the old word
    always @(posedge CLOCK) begin
        noise <= {noise[MAG_W-1:0], noise[MAG_W] ^ noise[MAG_W-2]};
        if (MEM_STORE.write === 1'b1) begin
            mem[MEM_STORE.addr] <= MEM_STORE.data;
        end
    end

    // read data only means something with an execute; junk otherwise
    assign MEM_RDATA = EXEC ? mem[EXEC_ADDR] : smr_word_type'(noise);

    // one execute, held up to the edge that takes it
    task automatic exec(input logic [ADDR_W-1:0] addr, input logic [1:0] kind);
        @(posedge CLOCK);
        EXEC       <= 1'b1;
        EXEC_ADDR  <= addr;
        ORDER_KIND <= kind;
        @(posedge CLOCK);
        EXEC <= 1'b0;
    endtask
endmodule

// >>> sim/smr_result_store_bench.sv
// self-checking bench for the serial multiply/divide result stage
// assumes the partner model supplies executes and holds the word memory
`timescale 1ns/1ns
module smr_result_store_bench;
    import smr_pkg::*;
    localparam smr_word_type NEXT_ORDER = '{mag: 43'h0123456789a, sign: 1'b1};

    logic              CLOCK = 1'b0;
    logic              SYS_RST = 1'b1;
    logic              EXEC;
    logic [1:0]        ORDER_KIND;
    logic [ADDR_W-1:0] EXEC_ADDR;
    logic              RESULT_READY;
    logic              CAP_EXCEEDED;
    logic              ORDER_VALID;
    smr_word_type      ORDER_WORD;
    logic [ADDR_W-1:0] GEN_ADDR;
    smr_word_type      MEM_RDATA;
    smr_store_type     MEM_STORE;
    int                n_fail = 0;
    int                comparisons = 0;
    int                cyc = 0;
    int                t_exec = 0;
    int                t_rdy = 0;
    logic              rdy_d = 1'b0;
    logic              last_cap;
    smr_store_type     wr_q[$];
    int                wr_cyc[$];

    always #4 CLOCK = ~CLOCK;

    smr_result_store smr_result_store_inst (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .EXEC(EXEC), .ORDER_KIND(ORDER_KIND),
        .EXEC_ADDR(EXEC_ADDR), .RESULT_READY(RESULT_READY), .CAP_EXCEEDED(CAP_EXCEEDED),
        .ORDER_VALID(ORDER_VALID), .ORDER_WORD(ORDER_WORD), .GEN_ADDR(GEN_ADDR),
        .MEM_RDATA(MEM_RDATA), .MEM_STORE(MEM_STORE)
    );

    smr_partner smr_partner_inst (
        .CLOCK(CLOCK), .EXEC(EXEC), .ORDER_KIND(ORDER_KIND), .EXEC_ADDR(EXEC_ADDR),
        .MEM_STORE(MEM_STORE), .MEM_RDATA(MEM_RDATA)
    );

    // stamps taken from pre-edge values, so no race with the design
    always @(posedge CLOCK) begin
        cyc = cyc + 1;
        if (EXEC === 1'b1) t_exec = cyc;
        if (RESULT_READY === 1'b1 && rdy_d !== 1'b1) t_rdy = cyc;
        rdy_d = RESULT_READY;
        if (MEM_STORE.write === 1'b1) begin
            wr_q.push_back(MEM_STORE);
            wr_cyc.push_back(cyc);
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic smr_store_type exp_st(input logic [ADDR_W-1:0] ad, input smr_word_type w);
        return '{write: 1'b1, addr: ad, data: '{mag: w.mag, sign: w.sign && (w.mag != 43'h0)}};
    endfunction

    // rounding by half a unit: keep 44 digits, add one, drop the last
    function automatic smr_word_type exp_div(input smr_word_type a, input smr_word_type b);
        logic [87:0] t;
        if (b.mag == 43'h0 || a.mag >= b.mag) return '{mag: MAG_ONES, sign: a.sign ^ b.sign};
        t = (({a.mag, 44'h0} / b.mag) + 88'h1) >> 1;
        return '{mag: t[42:0], sign: a.sign ^ b.sign};
    endfunction

    // one whole order: two operand executes, store, final execute
    task automatic run_op(input logic [1:0] kind, input smr_word_type a, input smr_word_type b,
                          input logic [ADDR_W-1:0] dst, input int n_wr, input int min_rdy);
        int n0;
        n0 = wr_q.size();
        smr_partner_inst.mem[10'h00a] = a;
        smr_partner_inst.mem[10'h00b] = b;
        smr_partner_inst.exec(10'h00a, kind);
        smr_partner_inst.exec(10'h00b, kind);
        for (int i = 0; i < 400 && RESULT_READY !== 1'b1; i++) @(posedge CLOCK);
        #1;
        last_cap = CAP_EXCEEDED;
        check(t_rdy - t_exec >= min_rdy && t_rdy - t_exec <= min_rdy + 16, 1'b1);
        smr_partner_inst.exec(dst, kind);
        repeat (8) @(posedge CLOCK);
        #1;
        check(wr_q.size() - n0, n_wr);
        check(wr_cyc[n0] - t_exec, 1);
        if (n_wr == 2) check(wr_cyc[n0+1] - wr_cyc[n0], MINOR_CLKS);
        smr_partner_inst.exec(10'h014, kind);
        #1;
        check({ORDER_VALID, ORDER_WORD}, {1'b1, NEXT_ORDER});
    endtask

    task automatic exact_case(input smr_word_type a, input smr_word_type b,
                              input logic [ADDR_W-1:0] dst);
        logic [85:0]       p;
        logic [ADDR_W-1:0] nxt;
        int                n0;
        p = 86'(a.mag) * 86'(b.mag);
        nxt = dst + 10'h001;
        n0 = wr_q.size();
        run_op(2'b01, a, b, dst, 2, 172);
        check(wr_q[n0], exp_st(dst, '{mag: p[85:43], sign: a.sign ^ b.sign}));
        check(wr_q[n0+1], exp_st(nxt, '{mag: p[42:0], sign: a.sign ^ b.sign}));
        check(GEN_ADDR, nxt);
    endtask

    task automatic sc_exact();
        exact_case('{mag: 43'h5a5a5a5a5a5, sign: 1'b0},
                   '{mag: 43'h3c3c3c3c3c3, sign: 1'b1}, 10'h155);
        exact_case('{mag: 43'h1, sign: 1'b0}, '{mag: 43'h1, sign: 1'b1}, 10'h3ff);
        exact_case('{mag: 43'h40000000000, sign: 1'b1},
                   '{mag: 43'h40000000000, sign: 1'b0}, 10'h007);
    endtask

    // rounded multiply and the spare kind code, both at the largest operands
    task automatic sc_round_mul();
        logic [85:0]  p;
        smr_word_type a;
        int           n0;
        a = '{mag: MAG_ONES, sign: 1'b0};
        p = 86'(a.mag) * 86'(a.mag);
        for (int k = 0; k < 4; k += 3) begin
            n0 = wr_q.size();
            run_op(2'(k), a, '{mag: a.mag, sign: 1'b1}, 10'h031, 1, 172);
            check(wr_q[n0], exp_st(10'h031, '{mag: 43'((p + (86'h1 << 42)) >> 43),
                                          sign: 1'b1}));
        end
    endtask

    task automatic div_case(input smr_word_type a, input smr_word_type b);
        smr_word_type e;
        int           n0;
        e = exp_div(a, b);
        n0 = wr_q.size();
        run_op(2'b10, a, b, 10'h2c0, 1, 176);
        check(wr_q[n0], exp_st(10'h2c0, e));
        check(last_cap, b.mag == 43'h0 || a.mag >= b.mag);
    endtask

    task automatic sc_divide();
        div_case('{mag: 43'h1, sign: 1'b1}, '{mag: 43'h3, sign: 1'b1});
        div_case('{mag: 43'h40000000000, sign: 1'b0},
                 '{mag: 43'h20000000000, sign: 1'b1});
        div_case('{mag: 43'h1234, sign: 1'b1}, '{mag: 43'h1234, sign: 1'b1});
        div_case('{mag: 43'h5, sign: 1'b1}, '{mag: 43'h0, sign: 1'b1});
        div_case('{mag: 43'h0, sign: 1'b1}, '{mag: 43'h7, sign: 1'b0});
    endtask

    task automatic summarize();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ten orders of about 200 clocks each; twelve and a half times that is a hang
    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    initial begin
        smr_partner_inst.mem[10'h014] = NEXT_ORDER;
        repeat (2) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        @(posedge CLOCK);
        #1;
        check({RESULT_READY, CAP_EXCEEDED, ORDER_VALID, MEM_STORE.write}, 4'h0);
        sc_exact();
        sc_round_mul();
        sc_divide();
        summarize();
    end
endmodule
